// ==== shared/srr_if.sv ====
// Serial link between the host controller and the security-area reader.
// Assumes the bench joins both modports; the output line idles high when undriven.
`timescale 1ns/100ps
interface srr_if;
	logic sclk;
	logic cs_n;
	logic serial_in_pin;
	logic serial_out;
	logic serial_out_oe;
	logic serial_out_line;

	// Resolved data-out wire, pulled high when released
	assign serial_out_line = serial_out_oe ? serial_out : 1'b1;

	modport dev (
		input sclk,
		input cs_n,
		input serial_in_pin,
		output serial_out,
		output serial_out_oe
	);

	modport host (
		output sclk,
		output cs_n,
		output serial_in_pin,
		input serial_out_line
	);
endinterface

// ==== shared/srr_pkg.sv ====
// Constants shared by both ends of the security-area read link.
// Assumes one system clock, mclk, on both ends.
package srr_pkg;

	// System clock
	localparam int CLK_NS = 40;

	// Command framing
	localparam logic [7:0] OPC_SEC_READ = 8'h48;
	localparam int OPC_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int DUMMY_BITS = 8;
	localparam int BYTE_BITS = 8;
	localparam int FRAME_BITS = OPC_BITS + ADDR_BITS + DUMMY_BITS;

	// Address field layout
	localparam int AREA_COUNT = 4;
	localparam int AREA_W = 2;
	localparam int AREA_BYTES = 256;
	localparam int PTR_W = 8;
	localparam int HI_MSB = 23;
	localparam int HI_LSB = 16;
	localparam int SEL_MSB = 15;
	localparam int SEL_LSB = 12;
	localparam int GAP_MSB = 11;
	localparam int GAP_LSB = 8;
	localparam int MEM_AW = AREA_W + PTR_W;

	// Serial clock timing: half period in mclk cycles
	localparam int SCLK_HALF_CYC = 8;

	// Least deselect time between frames
	localparam int DESEL_NS = 10;
	localparam int DESEL_CYC_RAW = (DESEL_NS + CLK_NS - 1) / CLK_NS;
	localparam int DESEL_CYC = (DESEL_CYC_RAW < 1) ? 1 : DESEL_CYC_RAW;

	// Values after reset
	localparam logic RST_CS_N = 1'b1;
	localparam logic RST_SCLK = 1'b0;
	localparam logic RST_LINE = 1'b0;

endpackage

// ==== sim/srr_monitor.sv ====
// Link checker for the security-area read link.
// Assumes every link pin is sampled on mclk and that the bench instantiates it beside srr_if.
`timescale 1ns/100ps
module srr_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in_pin,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic sclk_r;
	logic [5:0] rise_r;
	logic [5:0] rise_nxt;

	// Count sclk rises within a frame, saturating at 63
	always_comb begin
		rise_nxt = rise_r;
		if (cs_n)
			rise_nxt = 6'h00;
		else if (sclk && !sclk_r && rise_r != 6'h3f)
			rise_nxt = rise_r + 6'h01;
	end

	// Register the edge detector and the counter
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_r <= 1'b0;
			rise_r <= 6'h00;
		end else begin
			sclk_r <= sclk;
			rise_r <= rise_nxt;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_idle_hiz; cs_n [*6] |-> !serial_out_oe; endproperty
	a_idle_hiz: assert property (p_idle_hiz)
		else $error("output driven while deselected");
	property p_off; $rose(cs_n) |-> ##[1:6] !serial_out_oe; endproperty
	a_off: assert property (p_off)
		else $error("output not released after deselect");
	property p_oe_cnt; $rose(serial_out_oe) |-> rise_r == 6'h28; endproperty
	a_oe_cnt: assert property (p_oe_cnt)
		else $error("data phase not after 40 rises");
	property p_oe_low; $rose(serial_out_oe) |-> !sclk; endproperty
	a_oe_low: assert property (p_oe_low)
		else $error("output enabled while clock high");
	property p_hold;
		$rose(sclk) && serial_out_oe |-> ##1 ($stable(serial_out) || !serial_out_oe) [*6];
	endproperty
	a_hold: assert property (p_hold)
		else $error("data changed while clock high");
	property p_oe_keep; serial_out_oe && !cs_n |=> serial_out_oe; endproperty
	a_oe_keep: assert property (p_oe_keep)
		else $error("stream stopped while selected");
	property p_sclk_idle; cs_n |-> !sclk; endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("clock high while deselected");
	property p_din; $rose(sclk) && !cs_n |-> $past(serial_in_pin, 4) == serial_in_pin; endproperty
	a_din: assert property (p_din)
		else $error("input bit moved near rise");
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench joining host and device ends through srr_if.
// Assumes a 25 MHz mclk and that an undriven output line reads as ones.
`timescale 1ns/100ps
module testbench;
	logic mclk;
	logic rst_n;
	logic start;
	logic [23:0] addr;
	logic [8:0] nbytes;
	logic [7:0] rd_data;
	logic rd_valid;
	logic done;
	logic busy;
	logic busy_in;
	logic load_en;
	logic [9:0] load_addr;
	logic [7:0] load_data;
	logic busy_flag;
	logic [7:0] mem_exp [1024];
	logic [31:0] r;
	logic [23:0] ca [8] = '{24'h0010fe, 24'h003000, 24'h0020ff, 24'h000010, 24'h001005,
		24'h001100, 24'h004000, 24'h010000};
	int cn [8] = '{4, 2, 3, 1, 0, 2, 1, 1};
	int seed = 64995;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int i;

	srr_if link_if ();
	srr_host srr_host_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if.host), .start(start),
		.addr(addr), .nbytes(nbytes), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
		.busy(busy));
	srr_dev srr_dev_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if.dev), .busy_in(busy_in),
		.load_en(load_en), .load_addr(load_addr), .load_data(load_data), .busy_flag(busy_flag));
	srr_monitor srr_monitor_inst (.mclk(mclk), .rst_n(rst_n), .sclk(link_if.sclk),
		.cs_n(link_if.cs_n), .serial_in_pin(link_if.serial_in_pin),
		.serial_out(link_if.serial_out), .serial_out_oe(link_if.serial_out_oe));

	// Expected byte, ones when the frame is ignored
	function automatic logic [7:0] exp_byte(input logic [23:0] a, input int k, input logic bad);
		logic [7:0] b;
		b = a[7:0] + k[7:0];
		return bad ? 8'hff : mem_exp[{a[13:12], b}];
	endfunction

	task cmp(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single-bit status compare
	task cmp_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One read frame, every byte compared
	task automatic rd(input logic [23:0] a, input int n, input logic bad);
		int k;
		@(posedge mclk);
		start <= 1'b1;
		addr <= a;
		nbytes <= n[8:0];
		@(posedge mclk);
		start <= 1'b0;
		@(negedge mclk);
		cmp_flag(busy, 1'b1);
		for (k = 0; k < ((n == 0) ? 1 : n); k++) begin
			@(negedge mclk);
			while (rd_valid !== 1'b1) @(negedge mclk);
			cmp(rd_data, exp_byte(a, k, bad));
		end
		while (done !== 1'b1) @(negedge mclk);
		cmp_flag(busy, 1'b0);
	endtask

	task finish_test;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 50000) begin
			n_fail++;
			finish_test;
		end
	end

	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		addr = 24'h000000;
		nbytes = 9'h000;
		busy_in = 1'b0;
		load_en = 1'b0;
		load_addr = 10'h000;
		load_data = 8'h00;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		// Fill all four areas with random bytes
		for (i = 0; i < 1024; i++) begin
			@(posedge mclk);
			r = $random(seed);
			load_en <= 1'b1;
			load_addr <= i[9:0];
			load_data <= r[7:0];
			mem_exp[i] = r[7:0];
		end
		@(posedge mclk);
		load_en <= 1'b0;
		// Corner cases: wrap, edges, zero count, bad fields
		for (i = 0; i < 8; i++)
			rd(ca[i], cn[i], i >= 5);
		// Random area and start byte
		for (i = 0; i < 5; i++) begin
			r = $random(seed);
			rd({10'h000, r[1:0], 4'h0, r[9:2]}, r[11:10] + 1, 1'b0);
		end
		// Frame while a write cycle runs is ignored
		@(posedge mclk);
		busy_in <= 1'b1;
		repeat (2) @(negedge mclk);
		cmp_flag(busy_flag, 1'b1);
		rd(24'h001000, 2, 1'b1);
		@(posedge mclk);
		busy_in <= 1'b0;
		repeat (2) @(negedge mclk);
		cmp_flag(busy_flag, 1'b0);
		rd(24'h001000, 2, 1'b0);
		finish_test;
	end
endmodule

// ==== verilog/srr_dev.sv ====
// Device end: decodes the security-area read and streams area bytes out.
// Assumes the link pins come from the host asynchronously and are resynchronised
// here; the busy input comes from the erase/program engine on mclk.
`timescale 1ns/100ps
module srr_dev #(
	parameter int AREAS = srr_pkg::AREA_COUNT
) (
	input wire logic mclk,
	input wire logic rst_n,
	srr_if.dev link,
	input wire logic busy_in,
	input wire logic load_en,
	input wire logic [srr_pkg::MEM_AW-1:0] load_addr,
	input wire logic [7:0] load_data,
	output logic busy_flag
);
	typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_DUMMY, D_DATA, D_SKIP} srr_dst_e;

	localparam int DEPTH = AREAS * srr_pkg::AREA_BYTES;

	logic [7:0] mem [0:DEPTH-1];

	srr_dst_e st_r, st_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [23:0] sh_r, sh_nxt;
	logic [srr_pkg::AREA_W-1:0] area_r, area_nxt;
	logic [srr_pkg::PTR_W-1:0] ptr_r, ptr_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic dout_r, dout_nxt;
	logic oe_r, oe_nxt;
	logic busy_r, busy_nxt;

	logic sclk_s1, sclk_s2, sclk_d;
	logic cs_s1, cs_s2;
	logic din_s1, din_s2;
	logic rise, fall, selected;
	logic [23:0] sh_in;
	logic [7:0] cur_byte;

	assign link.serial_out = dout_r;
	assign link.serial_out_oe = oe_r;
	assign busy_flag = busy_r;

	// Pin synchronisers and serial clock edge history
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s1 <= srr_pkg::RST_SCLK;
			sclk_s2 <= srr_pkg::RST_SCLK;
			sclk_d <= srr_pkg::RST_SCLK;
			cs_s1 <= srr_pkg::RST_CS_N;
			cs_s2 <= srr_pkg::RST_CS_N;
			din_s1 <= srr_pkg::RST_LINE;
			din_s2 <= srr_pkg::RST_LINE;
		end else begin
			sclk_s1 <= link.sclk;
			sclk_s2 <= sclk_s1;
			sclk_d <= sclk_s2;
			cs_s1 <= link.cs_n;
			cs_s2 <= cs_s1;
			din_s1 <= link.serial_in_pin;
			din_s2 <= din_s1;
		end
	end

	// Edge strobes seen through the synchronisers
	assign rise = sclk_s2 & ~sclk_d;
	assign fall = ~sclk_s2 & sclk_d;
	assign selected = ~cs_s2;
	assign sh_in = {sh_r[22:0], din_s2};
	assign cur_byte = mem[{area_r, ptr_r}];

	// Area contents; filled by the programming path
	always_ff @(posedge mclk) begin
		if (load_en) begin
			mem[load_addr] <= load_data;
		end
	end

	// Command decoder and output shifter next state
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		area_nxt = area_r;
		ptr_nxt = ptr_r;
		bit_nxt = bit_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		busy_nxt = busy_in;
		if (!selected) begin
			// Deselect aborts any phase and releases the line
			st_nxt = D_IDLE;
			cnt_nxt = 5'h00;
			oe_nxt = 1'b0;
		end else begin
			case (st_r)
				D_IDLE: begin
					st_nxt = D_OPC;
					cnt_nxt = 5'h00;
					oe_nxt = 1'b0;
				end
				D_OPC: begin
					if (rise) begin
						sh_nxt = sh_in;
						cnt_nxt = cnt_r + 5'h01;
						if (cnt_r == 5'(srr_pkg::OPC_BITS - 1)) begin
							cnt_nxt = 5'h00;
							// Busy engine means the frame is dropped untouched
							if (sh_in[7:0] == srr_pkg::OPC_SEC_READ && !busy_in) begin
								st_nxt = D_ADDR;
							end else begin
								st_nxt = D_SKIP;
							end
						end
					end
				end
				D_ADDR: begin
					if (rise) begin
						sh_nxt = sh_in;
						cnt_nxt = cnt_r + 5'h01;
						if (cnt_r == 5'(srr_pkg::ADDR_BITS - 1)) begin
							cnt_nxt = 5'h00;
							// Fixed-zero fields checked, area in range
							if (sh_in[srr_pkg::HI_MSB:srr_pkg::HI_LSB] == 8'h00 &&
									sh_in[srr_pkg::GAP_MSB:srr_pkg::GAP_LSB] == 4'h0 &&
									32'(sh_in[srr_pkg::SEL_MSB:srr_pkg::SEL_LSB]) < AREAS) begin
								area_nxt = sh_in[srr_pkg::SEL_LSB +: srr_pkg::AREA_W];
								ptr_nxt = sh_in[srr_pkg::PTR_W-1:0];
								st_nxt = D_DUMMY;
							end else begin
								st_nxt = D_SKIP;
							end
						end
					end
				end
				D_DUMMY: begin
					if (rise) begin
						cnt_nxt = cnt_r + 5'h01;
						if (cnt_r == 5'(srr_pkg::DUMMY_BITS - 1)) begin
							cnt_nxt = 5'h00;
							bit_nxt = 3'h7;
							st_nxt = D_DATA;
						end
					end
				end
				D_DATA: begin
					if (fall) begin
						oe_nxt = 1'b1;
						dout_nxt = cur_byte[bit_r];
						bit_nxt = bit_r - 3'h1;
						if (bit_r == 3'h0) begin
							// Plain 8-bit pointer wraps inside the area
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				D_SKIP: begin
					oe_nxt = 1'b0;
				end
				default: begin
					st_nxt = D_SKIP;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// Command decoder and output shifter registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= D_IDLE;
			cnt_r <= 5'h00;
			sh_r <= 24'h0;
			area_r <= '0;
			ptr_r <= '0;
			bit_r <= 3'h7;
			dout_r <= srr_pkg::RST_LINE;
			oe_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			area_r <= area_nxt;
			ptr_r <= ptr_nxt;
			bit_r <= bit_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			busy_r <= busy_nxt;
		end
	end
endmodule

// ==== verilog/srr_host.sv ====
// Host controller end: issues one security-area read per start pulse.
// Assumes the device end is joined through srr_if and runs on the same mclk.
`timescale 1ns/100ps
module srr_host #(
	parameter int HALF = srr_pkg::SCLK_HALF_CYC,
	parameter int LEN_W = 9
) (
	input wire logic mclk,
	input wire logic rst_n,
	srr_if.host link,
	input wire logic start,
	input wire logic [23:0] addr,
	input wire logic [LEN_W-1:0] nbytes,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic busy
);
	typedef enum logic [1:0] {H_IDLE, H_CMD, H_READ, H_DESEL} srr_hst_e;

	srr_hst_e st_r, st_nxt;
	logic [7:0] div_r, div_nxt;
	logic sclk_r, sclk_nxt;
	logic cs_n_r, cs_n_nxt;
	logic mosi_r, mosi_nxt;
	logic [39:0] sh_r, sh_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic [LEN_W-1:0] left_r, left_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic done_r, done_nxt;
	logic busy_r, busy_nxt;
	logic miso_s1, miso_s2;
	logic tick;

	assign tick = (div_r == 8'(HALF - 1));
	assign link.sclk = sclk_r;
	assign link.cs_n = cs_n_r;
	assign link.serial_in_pin = mosi_r;
	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign done = done_r;
	assign busy = busy_r;

	// Data-out synchroniser
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			miso_s1 <= 1'b1;
			miso_s2 <= 1'b1;
		end else begin
			miso_s1 <= link.serial_out_line;
			miso_s2 <= miso_s1;
		end
	end

	// Frame sequencer next state
	always_comb begin
		st_nxt = st_r;
		sclk_nxt = sclk_r;
		cs_n_nxt = cs_n_r;
		mosi_nxt = mosi_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		byte_nxt = byte_r;
		left_nxt = left_r;
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = 1'b0;
		done_nxt = 1'b0;
		div_nxt = (st_r == H_IDLE || tick) ? 8'h00 : div_r + 8'h01;
		case (st_r)
			H_IDLE: begin
				if (start) begin
					// Address passed as given; area choice is software's
					sh_nxt = {srr_pkg::OPC_SEC_READ, addr, 8'h00};
					mosi_nxt = srr_pkg::OPC_SEC_READ[7];
					cs_n_nxt = 1'b0;
					cnt_nxt = 6'h00;
					byte_nxt = 8'h00;
					left_nxt = (nbytes == '0) ? LEN_W'(1) : nbytes;
					st_nxt = H_CMD;
				end
			end
			H_CMD: begin
				if (tick) begin
					if (!sclk_r) begin
						sclk_nxt = 1'b1;
						cnt_nxt = cnt_r + 6'h01;
					end else begin
						sclk_nxt = 1'b0;
						sh_nxt = {sh_r[38:0], 1'b0};
						mosi_nxt = sh_r[38];
						if (cnt_r == 6'(srr_pkg::FRAME_BITS)) begin
							cnt_nxt = 6'h00;
							st_nxt = H_READ;
						end
					end
				end
			end
			H_READ: begin
				if (tick) begin
					if (!sclk_r) begin
						sclk_nxt = 1'b1;
						byte_nxt = {byte_r[6:0], miso_s2};
						cnt_nxt = cnt_r + 6'h01;
						if (cnt_r == 6'(srr_pkg::BYTE_BITS - 1)) begin
							rd_data_nxt = {byte_r[6:0], miso_s2};
							rd_valid_nxt = 1'b1;
							left_nxt = left_r - LEN_W'(1);
						end
					end else begin
						sclk_nxt = 1'b0;
						if (cnt_r == 6'(srr_pkg::BYTE_BITS)) begin
							cnt_nxt = 6'h00;
							if (left_r == '0) begin
								st_nxt = H_DESEL;
							end
						end
					end
				end
			end
			H_DESEL: begin
				// Deselect only at a byte boundary
				if (tick) begin
					if (!cs_n_r) begin
						cs_n_nxt = 1'b1;
					end else begin
						done_nxt = 1'b1;
						st_nxt = H_IDLE;
					end
				end
			end
			default: begin
				st_nxt = H_IDLE;
				cs_n_nxt = 1'b1;
				sclk_nxt = 1'b0;
			end
		endcase
		busy_nxt = (st_nxt != H_IDLE);
	end

	// Frame sequencer registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= H_IDLE;
			div_r <= 8'h00;
			sclk_r <= srr_pkg::RST_SCLK;
			cs_n_r <= srr_pkg::RST_CS_N;
			mosi_r <= srr_pkg::RST_LINE;
			sh_r <= 40'h0;
			cnt_r <= 6'h00;
			byte_r <= 8'h00;
			left_r <= '0;
			rd_data_r <= 8'h00;
			rd_valid_r <= 1'b0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			sclk_r <= sclk_nxt;
			cs_n_r <= cs_n_nxt;
			mosi_r <= mosi_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			byte_r <= byte_nxt;
			left_r <= left_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			done_r <= done_nxt;
			busy_r <= busy_nxt;
		end
	end
endmodule
